// ==== src/port_pin_logic.sv ====
// General-purpose ports, pull-up control and edge detection with APB registers
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - Port zero: line zero input only; pull-up one bit for lines one to three
// - One pull-up bit enables all four lines of each of ports one, two, three, six and seven
// - Vectored irq zero is noise filtered before edge detection
// - Port three direction is set per bit
// - Port six, key returns zero to three, direction set per bit
// - Ports four and five are open drain, drive low only, float after reset
// - Programming mode: port four low nibble, port five high nibble
// - Eight bit-port outputs share pins with segment outputs 24 to 31
// - Vectored irq four detects a selectable rising or falling edge
// - Vectored irqs zero and one have selectable edge and raise requests
// - Test input two detects rising edges and sets a polled flag
// - Eight key-return lines; any falling edge sets the key flag
// - Sub oscillator pin readable as a one-bit test input
// - Low reset input holds the block in reset
module port_pin_logic
  import port_pkg::*;
(
  input wire logic pclk, // APB clock, 10 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [3:0] port_zero_in, // Port zero pin levels
  output logic [3:0] port_zero_pu, // Port zero pull-up enables
  input wire logic [3:0] port_one_in, // Port one pin levels
  output logic [3:0] port_one_pu, // Port one pull-up enables
  input wire logic [3:0] port_two_in, // Port two pin levels
  output logic [3:0] port_two_out, // Port two drive data
  output logic [3:0] port_two_oe, // Port two output enables
  output logic [3:0] port_two_pu, // Port two pull-up enables
  input wire logic [3:0] port_three_in, // Port three pin levels
  output logic [3:0] port_three_out, // Port three drive data
  output logic [3:0] port_three_oe, // Port three output enables
  output logic [3:0] port_three_pu, // Port three pull-up enables
  input wire logic [3:0] port_four_in, // Port four pin levels
  output logic [3:0] port_four_out, // Port four drive data, always low
  output logic [3:0] port_four_oe, // Port four pull-low enables
  input wire logic [3:0] port_five_in, // Port five pin levels
  output logic [3:0] port_five_out, // Port five drive data, always low
  output logic [3:0] port_five_oe, // Port five pull-low enables
  input wire logic [3:0] port_six_in, // Port six pin levels
  output logic [3:0] port_six_out, // Port six drive data
  output logic [3:0] port_six_oe, // Port six output enables
  output logic [3:0] port_six_pu, // Port six pull-up enables
  input wire logic [3:0] port_seven_in, // Port seven pin levels
  output logic [3:0] port_seven_out, // Port seven drive data
  output logic [3:0] port_seven_oe, // Port seven output enables
  output logic [3:0] port_seven_pu, // Port seven pull-up enables
  output logic [7:0] bit_port_outputs, // Bit-port data
  output logic [7:0] bit_port_sel, // 1 = pin is bit port, 0 = segment
  input wire logic sub_osc_input, // Sub oscillator pin level
  input wire logic prog_mode, // Program write/verify mode strap
  input wire logic [7:0] prog_data_out, // Byte to drive in verify
  input wire logic prog_data_drive, // Drive the byte in verify
  output logic [7:0] prog_data_in, // Byte seen on ports four/five
  output logic irq_zero_req, // Vectored request zero, pulse
  output logic irq_one_req, // Vectored request one, pulse
  output logic irq_four_req // Vectored request four, pulse
);
  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int NIN = 34;
  logic [NIN-1:0] pins;
  logic [NIN-1:0] meta_r;
  logic [NIN-1:0] sync_r;
  assign pins = {prog_mode, sub_osc_input, port_seven_in, port_six_in, port_five_in,
                 port_four_in, port_three_in, port_two_in, port_one_in, port_zero_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  logic [3:0] p0_s, p1_s, p2_s, p3_s, p4_s, p5_s, p6_s, p7_s;
  logic sub_s, prog_s;
  assign {prog_s, sub_s, p7_s, p6_s, p5_s, p4_s, p3_s, p2_s, p1_s, p0_s} = sync_r;

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [3:0] out2_r, out3_r, out4_r, out5_r, out6_r, out7_r;
  logic [3:0] dir3_r, dir6_r, oe2_r, oe7_r;
  logic [5:0] pullup_r;
  logic [7:0] bitport_r, segsel_r;
  logic [2:0] edge_r;
  logic [4:0] events_r;
  logic [4:0] ev_set;
  logic wr, rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  logic mapped;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_MISC);

  // Data registers: writes to data offsets store output latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out2_r <= RST_NIBBLE;
      out3_r <= RST_NIBBLE;
      out4_r <= RST_OPEN_DRAIN;
      out5_r <= RST_OPEN_DRAIN;
      out6_r <= RST_NIBBLE;
      out7_r <= RST_NIBBLE;
      oe2_r <= RST_NIBBLE;
      oe7_r <= RST_NIBBLE;
    end else if (wr) begin
      case (paddr)
        // Writing the data latch of port two or port seven turns all its lines to output
        OFF_PORT_TWO: begin
          out2_r <= pwdata[3:0];
          oe2_r <= 4'hf;
        end
        OFF_PORT_THREE: out3_r <= pwdata[3:0];
        OFF_PORT_FOUR: out4_r <= pwdata[3:0];
        OFF_PORT_FIVE: out5_r <= pwdata[3:0];
        OFF_PORT_SIX: out6_r <= pwdata[3:0];
        OFF_PORT_SEVEN: begin
          out7_r <= pwdata[3:0];
          oe7_r <= 4'hf;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir3_r <= RST_NIBBLE;
      dir6_r <= RST_NIBBLE;
      pullup_r <= RST_PULLUP;
      bitport_r <= RST_BYTE;
      segsel_r <= RST_BYTE;
      edge_r <= RST_EDGE;
    end else if (wr) begin
      case (paddr)
        OFF_DIR_THREE: dir3_r <= pwdata[3:0];
        OFF_DIR_SIX: dir6_r <= pwdata[3:0];
        OFF_PULLUP: pullup_r <= pwdata[5:0];
        OFF_BIT_PORT: bitport_r <= pwdata[7:0];
        OFF_SEG_SEL: segsel_r <= pwdata[7:0];
        OFF_EDGE_CFG: edge_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection
  logic irq0_f;
  noise_filter #(
    .STABLE(NOISE_CYCLES)
  ) u_irq0_filter (
    .pclk(pclk),
    .presetn(presetn),
    .din(p1_s[0]),
    .dout(irq0_f)
  );

  logic irq0_d_r, irq1_d_r, irq4_d_r, test2_d_r;
  logic [7:0] key_d_r;
  logic [7:0] keys;
  assign keys = {p7_s, p6_s};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq0_d_r <= 1'b0;
      irq1_d_r <= 1'b0;
      irq4_d_r <= 1'b0;
      test2_d_r <= 1'b0;
      // Matches the synchroniser's reset so no false falling edge follows reset
      key_d_r <= RST_BYTE;
    end else begin
      irq0_d_r <= irq0_f;
      irq1_d_r <= p1_s[1];
      irq4_d_r <= p0_s[0];
      test2_d_r <= p1_s[2];
      key_d_r <= keys;
    end
  end

  // Edge select: 1 picks rising, 0 picks falling
  function automatic logic edge_hit(input logic now, input logic was, input logic rise);
    edge_hit = rise ? (now && !was) : (!now && was);
  endfunction

  assign ev_set[EV_IRQ_ZERO] = edge_hit(irq0_f, irq0_d_r, edge_r[EDGE_IRQ_ZERO]);
  assign ev_set[EV_IRQ_ONE] = edge_hit(p1_s[1], irq1_d_r, edge_r[EDGE_IRQ_ONE]);
  assign ev_set[EV_IRQ_FOUR] = edge_hit(p0_s[0], irq4_d_r, edge_r[EDGE_IRQ_FOUR]);
  assign ev_set[EV_TEST_TWO] = p1_s[2] && !test2_d_r;
  assign ev_set[EV_KEY] = |(key_d_r & ~keys);

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_r <= RST_EVENTS;
    end else begin
      events_r <= (events_r & ~((wr && paddr == OFF_EVENTS) ? pwdata[4:0] : 5'h00)) | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_zero_req <= 1'b0;
      irq_one_req <= 1'b0;
      irq_four_req <= 1'b0;
    end else begin
      irq_zero_req <= ev_set[EV_IRQ_ZERO];
      irq_one_req <= ev_set[EV_IRQ_ONE];
      irq_four_req <= ev_set[EV_IRQ_FOUR];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_zero_pu <= RST_NIBBLE;
      port_one_pu <= RST_NIBBLE;
      port_two_pu <= RST_NIBBLE;
      port_three_pu <= RST_NIBBLE;
      port_six_pu <= RST_NIBBLE;
      port_seven_pu <= RST_NIBBLE;
      port_two_out <= RST_NIBBLE;
      port_two_oe <= RST_NIBBLE;
      port_three_out <= RST_NIBBLE;
      port_three_oe <= RST_NIBBLE;
      port_six_out <= RST_NIBBLE;
      port_six_oe <= RST_NIBBLE;
      port_seven_out <= RST_NIBBLE;
      port_seven_oe <= RST_NIBBLE;
      port_four_out <= RST_NIBBLE;
      port_four_oe <= RST_NIBBLE;
      port_five_out <= RST_NIBBLE;
      port_five_oe <= RST_NIBBLE;
      bit_port_outputs <= RST_BYTE;
      bit_port_sel <= RST_BYTE;
      prog_data_in <= RST_BYTE;
    end else begin
      // Line zero of port zero is input only, so it never gets a pull-up
      port_zero_pu <= {{3{pullup_r[PU_ZERO]}}, 1'b0};
      port_one_pu <= {4{pullup_r[PU_ONE]}};
      port_two_pu <= {4{pullup_r[PU_TWO]}};
      port_three_pu <= {4{pullup_r[PU_THREE]}};
      port_six_pu <= {4{pullup_r[PU_SIX]}};
      port_seven_pu <= {4{pullup_r[PU_SEVEN]}};
      port_two_out <= out2_r;
      port_two_oe <= oe2_r;
      port_three_out <= out3_r;
      port_three_oe <= dir3_r;
      port_six_out <= out6_r;
      port_six_oe <= dir6_r;
      port_seven_out <= out7_r;
      port_seven_oe <= oe7_r;
      port_four_out <= RST_NIBBLE;
      port_five_out <= RST_NIBBLE;
      if (prog_s) begin
        // Verify drives zeros of the byte; ones float to the external pull-up
        port_four_oe <= prog_data_drive ? ~prog_data_out[3:0] : 4'h0;
        port_five_oe <= prog_data_drive ? ~prog_data_out[7:4] : 4'h0;
      end else begin
        port_four_oe <= ~out4_r;
        port_five_oe <= ~out5_r;
      end
      prog_data_in <= {p5_s, p4_s};
      bit_port_outputs <= bitport_r;
      bit_port_sel <= segsel_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read and answer
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = RDATA_ZERO;
    case (paddr)
      OFF_PORT_ZERO: rd_nxt[3:0] = p0_s;
      OFF_PORT_ONE: rd_nxt[3:0] = p1_s;
      OFF_PORT_TWO: rd_nxt[3:0] = p2_s;
      OFF_PORT_THREE: rd_nxt[3:0] = p3_s;
      OFF_PORT_FOUR: rd_nxt[3:0] = p4_s;
      OFF_PORT_FIVE: rd_nxt[3:0] = p5_s;
      OFF_PORT_SIX: rd_nxt[3:0] = p6_s;
      OFF_PORT_SEVEN: rd_nxt[3:0] = p7_s;
      OFF_DIR_THREE: rd_nxt[3:0] = dir3_r;
      OFF_DIR_SIX: rd_nxt[3:0] = dir6_r;
      OFF_PULLUP: rd_nxt[5:0] = pullup_r;
      OFF_BIT_PORT: rd_nxt[7:0] = bitport_r;
      OFF_SEG_SEL: rd_nxt[7:0] = segsel_r;
      OFF_EDGE_CFG: rd_nxt[2:0] = edge_r;
      OFF_EVENTS: rd_nxt[4:0] = events_r;
      OFF_MISC: begin
        rd_nxt[MISC_PROG_MODE] = prog_s;
        rd_nxt[MISC_SUB_OSC] = sub_s;
      end
      default: rd_nxt = RDATA_ZERO;
    endcase
  end

  // Zero-wait slave: ready in the first access cycle, output from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : RDATA_ZERO;
    end
  end
endmodule

// ==== src/port_pkg.sv ====
// Shared constants for the port and pin-function logic over APB
package port_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_PORT_ZERO = 8'h00;
  localparam logic [7:0] OFF_PORT_ONE = 8'h04;
  localparam logic [7:0] OFF_PORT_TWO = 8'h08;
  localparam logic [7:0] OFF_PORT_THREE = 8'h0c;
  localparam logic [7:0] OFF_PORT_FOUR = 8'h10;
  localparam logic [7:0] OFF_PORT_FIVE = 8'h14;
  localparam logic [7:0] OFF_PORT_SIX = 8'h18;
  localparam logic [7:0] OFF_PORT_SEVEN = 8'h1c;
  localparam logic [7:0] OFF_DIR_THREE = 8'h20;
  localparam logic [7:0] OFF_DIR_SIX = 8'h24;
  localparam logic [7:0] OFF_PULLUP = 8'h28;
  localparam logic [7:0] OFF_BIT_PORT = 8'h2c;
  localparam logic [7:0] OFF_SEG_SEL = 8'h30;
  localparam logic [7:0] OFF_EDGE_CFG = 8'h34;
  localparam logic [7:0] OFF_EVENTS = 8'h38;
  localparam logic [7:0] OFF_MISC = 8'h3c;
  // Pull-up enable bit positions
  localparam int PU_ZERO = 0;
  localparam int PU_ONE = 1;
  localparam int PU_TWO = 2;
  localparam int PU_THREE = 3;
  localparam int PU_SIX = 4;
  localparam int PU_SEVEN = 5;
  // Edge select bit positions (1 = rising)
  localparam int EDGE_IRQ_ZERO = 0;
  localparam int EDGE_IRQ_ONE = 1;
  localparam int EDGE_IRQ_FOUR = 2;
  // Event bit positions
  localparam int EV_IRQ_ZERO = 0;
  localparam int EV_IRQ_ONE = 1;
  localparam int EV_IRQ_FOUR = 2;
  localparam int EV_TEST_TWO = 3;
  localparam int EV_KEY = 4;
  // Misc register bit positions
  localparam int MISC_PROG_MODE = 0;
  localparam int MISC_SUB_OSC = 1;
  // Reset values
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [3:0] RST_OPEN_DRAIN = 4'hf;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_PULLUP = 6'h00;
  localparam logic [2:0] RST_EDGE = 3'h0;
  localparam logic [4:0] RST_EVENTS = 5'h00;
  // Noise filter timing
  localparam int NOISE_MIN_NS = 300;
  localparam int CLK_PERIOD_NS = 100;
  localparam int NOISE_CYCLES = (NOISE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ==== src/noise_filter.sv ====
// Glitch filter: output follows input only after it has held steady
`timescale 1ns/10ps
module noise_filter
  import port_pkg::*;
#(
  parameter int STABLE = 3
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic din, // Synchronised input
  output logic dout // Filtered level
);
  logic [3:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_r <= 4'h0;
    end else if (cnt_r >= 4'(STABLE - 1)) begin
      cnt_r <= 4'h0;
      dout <= din;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// ==== tb/pin_env.sv ====
// Model of the switches, loads and pull-ups around the port pins
`timescale 1ns/10ps
module pin_env (
  input wire logic [3:0] port_two_out, // Drive data
  input wire logic [3:0] port_two_oe, // Drive enable
  input wire logic [3:0] port_three_out, // Drive data
  input wire logic [3:0] port_three_oe, // Drive enable
  input wire logic [3:0] port_six_out, // Drive data
  input wire logic [3:0] port_six_oe, // Drive enable
  input wire logic [3:0] port_seven_out, // Drive data
  input wire logic [3:0] port_seven_oe, // Drive enable
  input wire logic [3:0] port_four_oe, // Pull low
  input wire logic [3:0] port_five_oe, // Pull low
  input wire logic [3:0] x2, // Switch levels
  input wire logic [3:0] x3, // Switch levels
  input wire logic [3:0] x4, // Load level, 1 = pulled up
  input wire logic [3:0] x5, // Load level, 1 = pulled up
  input wire logic [3:0] x6, // Switch levels
  input wire logic [3:0] x7, // Switch levels
  output logic [3:0] port_two_in, // Pin level
  output logic [3:0] port_three_in, // Pin level
  output logic [3:0] port_four_in, // Pin level
  output logic [3:0] port_five_in, // Pin level
  output logic [3:0] port_six_in, // Pin level
  output logic [3:0] port_seven_in // Pin level
);
  // Switches sit behind series resistors, so a driving port wins the pin
  assign port_two_in = (port_two_oe & port_two_out) | (~port_two_oe & x2);
  assign port_three_in = (port_three_oe & port_three_out) | (~port_three_oe & x3);
  assign port_six_in = (port_six_oe & port_six_out) | (~port_six_oe & x6);
  assign port_seven_in = (port_seven_oe & port_seven_out) | (~port_seven_oe & x7);
  // Open drain: only a low is driven, the external pull-up gives the high
  assign port_four_in = ~port_four_oe & x4;
  assign port_five_in = ~port_five_oe & x5;
endmodule

// ==== tb/port_pin_logic_assertions.sv ====
// Concurrent checks on the port and pin-function block
`timescale 1ns/10ps
module port_checks
  import port_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB
  input wire logic penable, // APB
  input wire logic pwrite, // APB
  input wire logic pready, // APB
  input wire logic [7:0] paddr, // APB
  input wire logic [31:0] pwdata, // APB
  input wire logic [3:0] port_zero_in, // Pins
  input wire logic [3:0] port_one_in, // Pins
  input wire logic [3:0] port_four_in, // Pins
  input wire logic [3:0] port_five_in, // Pins
  input wire logic prog_mode, // Strap
  input wire logic [3:0] port_zero_pu, // Pull-ups
  input wire logic [3:0] port_one_pu, // Pull-ups
  input wire logic [3:0] port_two_pu, // Pull-ups
  input wire logic [3:0] port_three_pu, // Pull-ups
  input wire logic [3:0] port_six_pu, // Pull-ups
  input wire logic [3:0] port_seven_pu, // Pull-ups
  input wire logic [3:0] port_two_oe, // Enables
  input wire logic [3:0] port_three_oe, // Enables
  input wire logic [3:0] port_six_oe, // Enables
  input wire logic [3:0] port_seven_oe, // Enables
  input wire logic [3:0] port_four_oe, // Pull low
  input wire logic [3:0] port_five_oe, // Pull low
  input wire logic [3:0] port_four_out, // Drive data
  input wire logic [3:0] port_five_out, // Drive data
  input wire logic [7:0] prog_data_in, // Program byte
  input wire logic [7:0] bit_port_outputs, // Bit port
  input wire logic irq_zero_req, // Request
  input wire logic irq_one_req, // Request
  input wire logic irq_four_req // Request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic pu_ok;
  assign pu_ok = port_one_pu == {4{port_one_pu[0]}} && port_two_pu == {4{port_two_pu[0]}} &&
    port_three_pu == {4{port_three_pu[0]}} && port_six_pu == {4{port_six_pu[0]}} &&
    port_seven_pu == {4{port_seven_pu[0]}};
  sequence s_quiet;
    ($stable(port_four_in) && $stable(port_five_in) && prog_mode) [*5];
  endsequence
  sequence s_bp_write;
    psel && penable && pready && pwrite && paddr == OFF_BIT_PORT;
  endsequence
  a_od_low_only: assert property (port_four_out == 4'h0 && port_five_out == 4'h0)
    else $error("open-drain port drives high");
  a_pu_zero_group: assert property (!port_zero_pu[0] && port_zero_pu[3:1] == {3{port_zero_pu[1]}})
    else $error("port zero pull-ups not one group");
  a_pu_nibble_group: assert property (pu_ok)
    else $error("nibble pull-ups split");
  a_reset_inputs: assert property ($rose(presetn) |-> {port_two_oe, port_three_oe, port_six_oe,
    port_seven_oe, port_four_oe, port_five_oe} == 24'h000000)
    else $error("driver enabled after reset");
  a_prog_bytes: assert property (s_quiet ##0 $past(presetn, 8) |->
    prog_data_in == {port_five_in, port_four_in})
    else $error("program byte wrong");
  a_irq_one_cause: assert property (irq_one_req |-> $past(port_one_in[1], 2) != $past(port_one_in[1], 5))
    else $error("request one without edge");
  a_irq_four_cause: assert property (irq_four_req |->
    $past(port_zero_in[0], 2) != $past(port_zero_in[0], 5))
    else $error("request four without edge");
  a_irq_zero_cause: assert property (irq_zero_req |->
    $past(port_one_in[0], 2) != $past(port_one_in[0], 10))
    else $error("request zero without edge");
  a_req_one_cycle: assert property (({irq_zero_req, irq_one_req, irq_four_req} &
    $past({irq_zero_req, irq_one_req, irq_four_req})) == 3'b000)
    else $error("request longer than a cycle");
  a_bit_port_data: assert property (s_bp_write |-> ##2 bit_port_outputs == $past(pwdata[7:0], 2))
    else $error("bit port data wrong");
endmodule
bind port_pin_logic port_checks u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .paddr, .pwdata, .port_zero_in, .port_one_in, .port_four_in, .port_five_in, .prog_mode,
  .port_zero_pu, .port_one_pu, .port_two_pu, .port_three_pu, .port_six_pu, .port_seven_pu,
  .port_two_oe, .port_three_oe, .port_six_oe, .port_seven_oe, .port_four_oe, .port_five_oe,
  .port_four_out, .port_five_out, .prog_data_in, .bit_port_outputs, .irq_zero_req,
  .irq_one_req, .irq_four_req);

// ==== tb/test_port_pin_logic.sv ====
// Self-checking bench for the port and pin-function block
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h, expected %h", $time, a, b); end end
module test_port_pin_logic;
  import port_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic sub_osc_input = 0, prog_mode = 0, irq_zero_req, irq_one_req, irq_four_req;
  logic [7:0] paddr = 8'h00, bit_port_outputs, bit_port_sel, prog_data_in;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic prog_drive = 0;
  logic [7:0] prog_byte = 8'h00;
  logic [3:0] port_zero_in = 4'h0, port_one_in = 4'h0, x2 = 4'h0, x3 = 4'h3, x4 = 4'h6;
  logic [3:0] x5 = 4'h3, x6 = 4'h5, x7 = 4'hf, port_zero_pu, port_one_pu, port_two_pu;
  logic [3:0] port_three_pu, port_six_pu, port_seven_pu, port_two_in, port_three_in;
  logic [3:0] port_four_in, port_five_in, port_six_in, port_seven_in, port_two_out;
  logic [3:0] port_three_out, port_four_out, port_five_out, port_six_out, port_seven_out;
  logic [3:0] port_two_oe, port_three_oe, port_four_oe, port_five_oe, port_six_oe, port_seven_oe;
  int check_count = 0, miscompares = 0, n0 = 0, n1 = 0, n4 = 0;
  always #50 pclk = ~pclk;
  // Counting only out of reset keeps unknown requests out of the totals
  always @(posedge pclk) begin
    if (presetn) begin
      n0 <= n0 + irq_zero_req;
      n1 <= n1 + irq_one_req;
      n4 <= n4 + irq_four_req;
    end
  end
  port_pin_logic DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port_zero_in, .port_zero_pu, .port_one_in, .port_one_pu, .port_two_in,
    .port_two_out, .port_two_oe, .port_two_pu, .port_three_in, .port_three_out, .port_three_oe,
    .port_three_pu, .port_four_in, .port_four_out, .port_four_oe, .port_five_in, .port_five_out,
    .port_five_oe, .port_six_in, .port_six_out, .port_six_oe, .port_six_pu, .port_seven_in,
    .port_seven_out, .port_seven_oe, .port_seven_pu, .bit_port_outputs, .bit_port_sel,
    .sub_osc_input, .prog_mode, .prog_data_out(prog_byte), .prog_data_drive(prog_drive),
    .prog_data_in,
    .irq_zero_req, .irq_one_req, .irq_four_req);
  pin_env env (.port_two_out, .port_two_oe, .port_three_out, .port_three_oe, .port_six_out,
    .port_six_oe, .port_seven_out, .port_seven_oe, .port_four_oe, .port_five_oe, .x2, .x3, .x4,
    .x5, .x6, .x7, .port_two_in, .port_three_in, .port_four_in, .port_five_in, .port_six_in,
    .port_seven_in);
  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request is held from setup until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i == 16) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  initial begin
    tick(12);
    presetn <= 1'b1;
    tick(1);
    `CHK({port_two_oe, port_three_oe, port_six_oe, port_seven_oe}, 16'h0000)
    `CHK({port_four_oe, port_five_oe}, 8'h00)
    rchk(OFF_DIR_THREE, 32'h0);
    $display("test reset done");
    wr(OFF_PULLUP, 32'h3f);
    tick(2);
    `CHK({port_zero_pu, port_one_pu, port_two_pu, port_three_pu}, 16'hefff)
    wr(OFF_PULLUP, 32'h2a);
    tick(2);
    `CHK({port_zero_pu, port_one_pu, port_two_pu, port_three_pu, port_six_pu, port_seven_pu},
      24'h0f0f0f)
    $display("test pull-ups done");
    wr(OFF_PORT_THREE, 32'ha);
    wr(OFF_DIR_THREE, 32'h5);
    wr(OFF_PORT_SIX, 32'h6);
    wr(OFF_DIR_SIX, 32'h9);
    wr(OFF_PORT_FOUR, 32'h6);
    wr(OFF_PORT_FIVE, 32'h3);
    tick(4);
    `CHK({port_three_oe, port_three_out}, 8'h5a)
    `CHK({port_six_oe, port_six_out}, 8'h96)
    rchk(OFF_PORT_THREE, 32'h2);
    rchk(OFF_PORT_SIX, 32'h4);
    `CHK({port_five_oe, port_four_oe, port_five_out, port_four_out}, 16'hc900)
    rchk(OFF_PORT_FOUR, 32'h6);
    prog_mode <= 1'b1;
    tick(8);
    `CHK(prog_data_in, 8'h36)
    rchk(OFF_MISC, 32'h1);
    prog_byte <= 8'h5a;
    prog_drive <= 1'b1;
    tick(6);
    `CHK({port_five_oe, port_four_oe, prog_data_in}, 16'ha512)
    prog_drive <= 1'b0;
    prog_mode <= 1'b0;
    $display("test directions done");
    wr(OFF_BIT_PORT, 32'ha5);
    wr(OFF_SEG_SEL, 32'h0f);
    tick(3);
    `CHK({bit_port_outputs, bit_port_sel}, 16'ha50f)
    wr(OFF_EDGE_CFG, 32'h7);
    port_one_in <= 4'h1;
    tick(1);
    port_one_in <= 4'h0;
    tick(12);
    `CHK(n0, 0)
    // Port six direction change made a real key-return fall; start clean
    wr(OFF_EVENTS, 32'h1f);
    // Rising then falling edges under each edge setting: one request each time
    for (int k = 0; k < 2; k++) begin
      wr(OFF_EDGE_CFG, k ? 32'h0 : 32'h7);
      port_one_in <= 4'h7;
      port_zero_in <= 4'h1;
      tick(12);
      port_one_in <= 4'h0;
      port_zero_in <= 4'h0;
      tick(12);
    end
    `CHK({n0[7:0], n1[7:0], n4[7:0]}, 24'h020202)
    rchk(OFF_EVENTS, 32'h0f);
    wr(OFF_EVENTS, 32'h1f);
    port_one_in <= 4'h4;
    tick(12);
    rchk(OFF_EVENTS, 32'h08);
    wr(OFF_EVENTS, 32'h1f);
    port_one_in <= 4'h0;
    tick(12);
    rchk(OFF_EVENTS, 32'h00);
    x7 <= 4'hb;
    tick(12);
    rchk(OFF_EVENTS, 32'h10);
    wr(OFF_EVENTS, 32'h1f);
    x7 <= 4'hf;
    tick(12);
    rchk(OFF_EVENTS, 32'h00);
    x6 <= 4'h1;
    tick(12);
    rchk(OFF_EVENTS, 32'h10);
    $display("test edges done");
    sub_osc_input <= 1'b1;
    tick(4);
    rchk(OFF_MISC, 32'h2);
    wr(OFF_PORT_TWO, 32'hc);
    wr(OFF_PORT_SEVEN, 32'h3);
    tick(3);
    `CHK({port_two_oe, port_two_out, port_seven_oe, port_seven_out}, 16'hfcf3)
    xfer(1'b0, 8'h40, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    presetn <= 1'b0;
    tick(3);
    `CHK({bit_port_outputs, port_two_oe, port_three_oe, port_six_oe, port_seven_oe},
      24'h000000)
    presetn <= 1'b1;
    rchk(OFF_DIR_SIX, 32'h0);
    $display("test misc and reset done");
    conclude();
  end
endmodule
